// [verilog/eqs_cfg.svh]
// Purpose: Offsets, field positions, reset values and timing counts
//          for the egress QoS scheduler.
// Assumes: Included by its bare name from the scheduler module.
// Notes:   Byte addresses on an 8-bit register address, one word each.
//
// What this block does
// [R1] Default map: pri 0-1,2-3,4-5,6-7 to queues 0-3
// [R2] Tag enabled: take priority from 802.1p tag
// [R3] IP enabled: take priority from DiffServ/traffic class
// [R4] Both enabled: precedence bit picks winner, tag default
// [R5] Remap table turns tag priority into new priority
// [R6] One congestion policy shared by both ports
// [R7] Strict: higher queue always served first
// [R8] Weighted: per round 8,4,2,1 frames from queues 3-0
// [R9] Optional interlink ingress rate limit, none to 90
// [R10] Optional interlink egress rate limit, none to 90
// [R11] Weighted: empty queue yields turn without idling
`ifndef EQS_CFG_SVH
`define EQS_CFG_SVH

// Register byte addresses
`define EQS_A_CTRL 8'h00
`define EQS_A_REMAP 8'h04
`define EQS_A_QMAP 8'h08
`define EQS_A_RATE 8'h0C
`define EQS_A_STAT 8'h10
`define EQS_A_DROP 8'h14

// Control register fields
`define EQS_B_TAG 0
`define EQS_B_IP 1
`define EQS_B_PREC 2
`define EQS_B_WFQ 3
`define EQS_B_EGLNK 4
`define EQS_CTRL_W 5
`define EQS_CTRL_RST 5'h13

// Remap: identity; queue map: two priorities per queue
`define EQS_REMAP_RST 24'hFAC688
`define EQS_QMAP_RST 16'hFA50

// Rate field: Mbps, zero means no limit
`define EQS_RATE_W 7
`define EQS_RATE_MAX 7'h5A
`define EQS_RATE_RST 7'h00
`define EQS_EGR_LSB 8

// Weights of queues 3..0
`define EQS_W3 4'h8
`define EQS_W2 4'h4
`define EQS_W1 4'h2
`define EQS_W0 4'h1

// Priority bits of the DiffServ / traffic class byte
`define EQS_IP_MSB 7
`define EQS_IP_LSB 5

// Timing: tokens in bits are added once per microsecond
`define EQS_CLK_NS 100
`define EQS_TICK_NS 1000
`define EQS_TICK_CYC (`EQS_TICK_NS / `EQS_CLK_NS)

`endif

// [verilog/eqs_pkg.sv]
// Purpose: Shared types of the egress QoS scheduler.
// Assumes: Nothing beyond the standard language.
// Notes:   Constants live in eqs_cfg.svh.
`default_nettype none
package eqs_pkg;
  typedef logic [2:0] eqs_pri_t;
  typedef logic [1:0] eqs_q_t;
  typedef logic [3:0] eqs_cr_t;
endpackage
`default_nettype wire

// [verilog/eqs_sched.sv]
// Purpose: Classify ingress frames onto four egress queues and serve
//          them by strict or 8:4:2:1 weighted policy with rate limits.
// Assumes: Queues hold frame counts; frame data sits in the switch.
// Notes:   Ingress limit polices (drops), egress limit shapes (waits).
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "eqs_cfg.svh"

module eqs_sched
  import eqs_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int BURST = 24576,
  parameter int TW = 18
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic in_valid,
  input wire logic in_port_link,
  input wire logic in_tagged,
  input wire logic [2:0] in_tag_pri,
  input wire logic in_ip_ok,
  input wire logic [7:0] in_ip_tc,
  input wire logic [10:0] in_len,
  output logic cls_valid,
  output logic [1:0] cls_queue,
  output logic cls_drop,
  input wire logic eg_ready,
  input wire logic eg_done,
  input wire logic [10:0] eg_len,
  output logic tx_grant,
  output logic [1:0] tx_queue
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [TW-1:0] BKT = TW'(BURST);
  localparam logic [3:0] TICK_LAST = 4'(`EQS_TICK_CYC - 1);

  // Configuration and status registers
  logic [`EQS_CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [23:0] remap_r, remap_nxt;
  logic [15:0] qmap_r, qmap_nxt;
  logic [`EQS_RATE_W-1:0] irate_r, irate_nxt;
  logic [`EQS_RATE_W-1:0] erate_r, erate_nxt;
  logic [15:0] drops_r, drops_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  // Datapath state
  logic [CW-1:0] cnt_r [4];
  logic [CW-1:0] cnt_nxt [4];
  eqs_cr_t cr_r [4];
  eqs_cr_t cr_nxt [4];
  logic [3:0] tick_r, tick_nxt;
  logic [TW-1:0] itok_r, itok_nxt;
  logic [TW-1:0] etok_r, etok_nxt;
  logic cv_r, cv_nxt;
  eqs_q_t cq_r, cq_nxt;
  logic cd_r, cd_nxt;
  logic tg_r, tg_nxt;
  eqs_q_t tq_r, tq_nxt;

  // Combinational helpers
  eqs_pri_t tag_p, ip_p, pri;
  eqs_q_t q_in, q_out;
  logic use_tag, use_ip, accept, can_send, shaped_ok, tick;
  logic [3:0] nonempty, ready_cr;
  logic [13:0] in_bits, eg_bits;
  eqs_cr_t wt [4];

  // Highest set bit of a queue mask; queue 3 has highest priority
  function automatic eqs_q_t top_q(input logic [3:0] m);
    eqs_q_t r;
    r = 2'h0;
    if (m[3]) begin
      r = 2'h3;
    end else if (m[2]) begin
      r = 2'h2;
    end else if (m[1]) begin
      r = 2'h1;
    end
    return r;
  endfunction

  // Clamp a rate request to the legal range
  function automatic logic [`EQS_RATE_W-1:0] clamp(input logic [6:0] v);
    return (v > `EQS_RATE_MAX) ? `EQS_RATE_MAX : v;
  endfunction

  // Register bus: writes land at once, reads answer one cycle later
  always_comb begin
    ctrl_nxt = ctrl_r;
    remap_nxt = remap_r;
    qmap_nxt = qmap_r;
    irate_nxt = irate_r;
    erate_nxt = erate_r;
    drops_nxt = drops_r;
    rdata_nxt = 32'h0000_0000;
    if (cls_valid && cls_drop && drops_r != 16'hFFFF) begin
      drops_nxt = drops_r + 16'h0001;
    end
    if (reg_wr) begin
      case (reg_addr)
        `EQS_A_CTRL: ctrl_nxt = reg_wdata[`EQS_CTRL_W-1:0]; // R6
        `EQS_A_REMAP: remap_nxt = reg_wdata[23:0]; // R5
        `EQS_A_QMAP: qmap_nxt = reg_wdata[15:0];
        `EQS_A_RATE: begin
          irate_nxt = clamp(reg_wdata[6:0]); // R9
          erate_nxt = clamp(reg_wdata[`EQS_EGR_LSB +: 7]); // R10
        end
        // Writing the drop counter clears it; a same-cycle drop is kept
        `EQS_A_DROP: drops_nxt = (cls_valid && cls_drop) ? 16'h0001 : 16'h0000;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `EQS_A_CTRL: rdata_nxt = {27'h0, ctrl_r};
        `EQS_A_REMAP: rdata_nxt = {8'h00, remap_r};
        `EQS_A_QMAP: rdata_nxt = {16'h0000, qmap_r};
        `EQS_A_RATE: rdata_nxt = {17'h0, erate_r, 1'b0, irate_r};
        `EQS_A_STAT: begin
          for (int i = 0; i < 4; i++) begin
            rdata_nxt[i*8 +: 8] = 8'(cnt_r[i]);
          end
        end
        `EQS_A_DROP: rdata_nxt = {16'h0000, drops_r};
        default: rdata_nxt = 32'h0000_0000; // Unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctrl_r <= `EQS_CTRL_RST; // R2 R3 R4
      remap_r <= `EQS_REMAP_RST;
      qmap_r <= `EQS_QMAP_RST; // R1
      irate_r <= `EQS_RATE_RST; // R9
      erate_r <= `EQS_RATE_RST; // R10
      drops_r <= 16'h0000;
      rdata_r <= 32'h0000_0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      remap_r <= remap_nxt;
      qmap_r <= qmap_nxt;
      irate_r <= irate_nxt;
      erate_r <= erate_nxt;
      drops_r <= drops_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Classification, policing, queue bookkeeping and service order
  always_comb begin
    wt[3] = `EQS_W3;
    wt[2] = `EQS_W2;
    wt[1] = `EQS_W1;
    wt[0] = `EQS_W0;
    tick = (tick_r == TICK_LAST);
    tick_nxt = tick ? 4'h0 : tick_r + 4'h1;

    // Source of priority for this frame
    tag_p = remap_r[in_tag_pri*3 +: 3]; // R5
    ip_p = in_ip_tc[`EQS_IP_MSB:`EQS_IP_LSB]; // R3
    use_tag = ctrl_r[`EQS_B_TAG] && in_tagged; // R2
    use_ip = ctrl_r[`EQS_B_IP] && in_ip_ok; // R3
    if (use_tag && (!use_ip || !ctrl_r[`EQS_B_PREC])) begin
      pri = tag_p; // R4
    end else if (use_ip) begin
      pri = ip_p; // R4
    end else begin
      pri = 3'h0; // Unclassified frames ride the lowest priority
    end
    q_in = qmap_r[pri*2 +: 2]; // R1

    // Ingress token bucket in bits; idle buckets sit full
    in_bits = {in_len, 3'h0};
    itok_nxt = itok_r;
    if (irate_r == `EQS_RATE_RST) begin
      itok_nxt = BKT;
    end else if (tick) begin
      itok_nxt = (itok_r + TW'(irate_r) > BKT) ? BKT : itok_r + TW'(irate_r);
    end
    accept = (cnt_r[q_in] != FULL);
    if (in_port_link && irate_r != `EQS_RATE_RST) begin
      accept = accept && (itok_r >= TW'(in_bits)); // R9
    end
    if (in_valid && accept && in_port_link && irate_r != `EQS_RATE_RST) begin
      itok_nxt = itok_nxt - TW'(in_bits); // R9
    end

    // Egress shaper: signed credit may dip below zero after a frame
    eg_bits = {eg_len, 3'h0};
    etok_nxt = etok_r;
    if (erate_r == `EQS_RATE_RST || !ctrl_r[`EQS_B_EGLNK]) begin
      etok_nxt = BKT;
    end else begin
      if (tick && !etok_r[TW-1] && etok_r + TW'(erate_r) > BKT) begin
        etok_nxt = BKT;
      end else if (tick) begin
        etok_nxt = etok_r + TW'(erate_r);
      end
      if (eg_done) begin
        etok_nxt = etok_nxt - TW'(eg_bits); // R10
      end
    end
    shaped_ok = !etok_r[TW-1]; // R10

    // Pick a queue under the shared policy
    for (int i = 0; i < 4; i++) begin
      nonempty[i] = (cnt_r[i] != '0);
      ready_cr[i] = nonempty[i] && (cr_r[i] != 4'h0);
      cr_nxt[i] = cr_r[i];
    end
    if (!ctrl_r[`EQS_B_WFQ]) begin
      q_out = top_q(nonempty); // R7
    end else if (ready_cr != 4'h0) begin
      q_out = top_q(ready_cr); // R8 R11
    end else begin
      q_out = top_q(nonempty); // R11
    end
    // A grant blocks the next cycle so a slow ready drop is safe
    can_send = eg_ready && !tg_r && (nonempty != 4'h0) && shaped_ok; // R10
    if (can_send && ctrl_r[`EQS_B_WFQ]) begin
      if (ready_cr == 4'h0) begin
        // Round spent or only starved queues left: start a new round
        for (int i = 0; i < 4; i++) begin
          cr_nxt[i] = wt[i]; // R8
        end
      end
      cr_nxt[q_out] = cr_nxt[q_out] - 4'h1; // R8
    end

    // Frame counts: enqueue and dequeue may meet on one queue
    for (int i = 0; i < 4; i++) begin
      cnt_nxt[i] = cnt_r[i];
      if (in_valid && accept && q_in == eqs_q_t'(i)) begin
        cnt_nxt[i] = cnt_nxt[i] + CW'(1);
      end
      if (can_send && q_out == eqs_q_t'(i)) begin
        cnt_nxt[i] = cnt_nxt[i] - CW'(1);
      end
    end

    // Registered results
    cv_nxt = in_valid;
    cq_nxt = in_valid ? q_in : cq_r;
    cd_nxt = in_valid && !accept;
    tg_nxt = can_send;
    tq_nxt = can_send ? q_out : tq_r;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      for (int i = 0; i < 4; i++) begin
        cnt_r[i] <= '0;
        cr_r[i] <= 4'h0;
      end
      tick_r <= 4'h0;
      itok_r <= BKT;
      etok_r <= BKT;
      cv_r <= 1'b0;
      cq_r <= 2'h0;
      cd_r <= 1'b0;
      tg_r <= 1'b0;
      tq_r <= 2'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        cnt_r[i] <= cnt_nxt[i];
        cr_r[i] <= cr_nxt[i];
      end
      tick_r <= tick_nxt;
      itok_r <= itok_nxt;
      etok_r <= etok_nxt;
      cv_r <= cv_nxt;
      cq_r <= cq_nxt;
      cd_r <= cd_nxt;
      tg_r <= tg_nxt;
      tq_r <= tq_nxt;
    end
  end

  // Every output straight from a flip-flop
  assign reg_rdata = rdata_r;
  assign cls_valid = cv_r;
  assign cls_queue = cq_r;
  assign cls_drop = cd_r;
  assign tx_grant = tg_r;
  assign tx_queue = tq_r;

endmodule // eqs_sched
`default_nettype wire

// [tb/eqs_sched_props.sv]
// Purpose: Port checks for the egress QoS scheduler.
// Assumes: Bound to the scheduler; one clock.
// Notes:   Queue order itself is judged by the bench.
`timescale 1ns/10ps
`default_nettype none
module eqs_sched_props (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic in_valid,
  input wire logic cls_valid,
  input wire logic cls_drop,
  input wire logic [1:0] cls_queue,
  input wire logic eg_ready,
  input wire logic tx_grant,
  input wire logic [1:0] tx_queue
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Every descriptor gets exactly one answer, one cycle later
  AST_CLS_LAT: assert property (in_valid |=> cls_valid) else $error("no answer");
  AST_CLS_NONE: assert property (!in_valid |=> !cls_valid) else $error("stray answer");
  AST_DROP: assert property (cls_drop |-> cls_valid) else $error("stray drop");
  AST_CLSQ: assert property (!cls_valid |-> $stable(cls_queue)) else $error("queue moved");
  // Grants need an idle port and never come back to back
  AST_GAP: assert property (tx_grant |=> !tx_grant) else $error("grants adjacent");
  AST_RDY: assert property (tx_grant |-> $past(eg_ready)) else $error("grant on busy");
  AST_TXQ: assert property (!tx_grant |-> $stable(tx_queue)) else $error("tx queue moved");
  AST_RD: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("read data lingers");
  cover property (tx_grant && tx_queue == 2'h0);
  cover property (cls_drop);
  cover property (tx_grant ##2 tx_grant);
endmodule // eqs_sched_props
`default_nettype wire

// [tb/eqs_egress_model.sv]
// Purpose: Egress transmitter that takes grants and reports frames sent.
// Assumes: One frame in flight; service time varies from frame to frame.
// Notes:   hold stalls the port so the bench can fill queues first.
`timescale 1ns/10ps
`default_nettype none
module eqs_egress_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic hold,
  input wire logic tx_grant,
  output logic eg_ready,
  output var logic eg_done = 1'b0,
  output var logic [10:0] eg_len = 11'h000
);
  logic busy_r = 1'b0;
  logic [7:0] tick_r = 8'h00;
  logic [1:0] wait_r = 2'h0;
  // Ready falls the cycle after a grant, inside the allowed window
  assign eg_ready = rstn && !hold && !busy_r;
  // Length is only meaningful with done, so it toggles otherwise
  always @(posedge mclk) begin
    tick_r <= tick_r + 8'h01;
    eg_done <= 1'b0;
    eg_len <= ~eg_len;
    if (!rstn) begin
      busy_r <= 1'b0;
    end else if (tx_grant) begin
      busy_r <= 1'b1;
      wait_r <= tick_r[1:0];
    end else if (busy_r && wait_r != 2'h0) begin
      wait_r <= wait_r - 2'h1;
    end else if (busy_r) begin
      busy_r <= 1'b0;
      eg_done <= 1'b1;
      eg_len <= {3'h0, tick_r} + 11'h040;
    end
  end
endmodule // eqs_egress_model
`default_nettype wire

// [tb/eqs_sched_tb_top.sv]
// Purpose: Self-checking bench for the egress QoS scheduler.
// Assumes: Small bucket so the ingress limit bites at once.
// Notes:   Grant order is judged by the pick reference below.
`timescale 1ns/10ps
`default_nettype none
`include "eqs_cfg.svh"
module eqs_sched_tb_top;
  localparam int DEPTH = 16;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic hold = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic in_valid = 1'b0;
  logic lk = 1'b0;
  logic tg = 1'b0;
  logic ipok = 1'b0;
  logic [2:0] pri = 3'h0;
  logic [7:0] tc = 8'h00;
  logic [10:0] len = 11'h040;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] x = 32'h21CD;
  logic [31:0] reg_rdata, rd;
  logic cls_valid, cls_drop, eg_ready, eg_done, tx_grant;
  logic [1:0] cls_queue, tx_queue;
  logic [10:0] eg_len;
  logic [2:0] q;
  logic [23:0] m;
  logic [1:0] gq[$];
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;
  int cnt[4];
  int cr[4];
  always #50 mclk = ~mclk;
  eqs_sched #(.DEPTH(DEPTH), .BURST(2048)) dut (.mclk(mclk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .in_valid(in_valid), .in_port_link(lk), .in_tagged(tg),
    .in_tag_pri(pri), .in_ip_ok(ipok), .in_ip_tc(tc), .in_len(len), .cls_valid(cls_valid),
    .cls_queue(cls_queue), .cls_drop(cls_drop), .eg_ready(eg_ready), .eg_done(eg_done),
    .eg_len(eg_len), .tx_grant(tx_grant), .tx_queue(tx_queue));
  eqs_egress_model u_eg (.mclk(mclk), .rstn(rstn), .hold(hold), .tx_grant(tx_grant),
    .eg_ready(eg_ready), .eg_done(eg_done), .eg_len(eg_len));
  // Grant log and hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (tx_grant === 1'b1) gq.push_back(tx_queue);
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic test_done();
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic void rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
  endfunction
  // Reference: strict takes the top nonempty queue; weighted spends
  // 8,4,2,1 credits and reloads only when no waiting queue has any left
  function automatic int pick(input bit wfq);
    int s = -1;
    for (int r = 0; r < 2 && s < 0; r++) begin
      if (r == 1) cr = '{1, 2, 4, 8};
      for (int k = 3; k >= 0; k--) if (s < 0 && cnt[k] > 0 && (!wfq || cr[k] > 0)) s = k;
    end
    cnt[s]--;
    cr[s]--;
    return s;
  endfunction
  task automatic reset();
    rstn <= 1'b0;
    hold <= 1'b1;
    cr = '{0, 0, 0, 0};
    cnt = '{0, 0, 0, 0};
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  // One descriptor; q returns {drop, queue} from the answer cycle
  task automatic frame(input logic l, t, input logic [2:0] p, input logic i,
                       input logic [7:0] c, input logic [10:0] n);
    @(posedge mclk);
    in_valid <= 1'b1;
    lk <= l;
    tg <= t;
    pri <= p;
    ipok <= i;
    tc <= c;
    len <= n;
    @(posedge mclk);
    in_valid <= 1'b0;
    #1 q = {cls_drop, cls_queue};
  endtask
  // Random fill with the port stalled, then drain against the reference
  task automatic fill_drain(input bit wfq);
    int n;
    for (int i = 0; i < 24; i++) begin
      rnd();
      frame(1'b0, 1'b1, x[2:0], 1'b0, 8'h00, 11'h040);
      chk({29'h0, q}, {29'h0, cnt[x[2:1]] == DEPTH, x[2:1]});
      if (cnt[x[2:1]] < DEPTH) cnt[x[2:1]]++;
    end
    n = cnt[0] + cnt[1] + cnt[2] + cnt[3];
    gq.delete();
    hold <= 1'b0;
    for (int i = 0; i < 3000 && gq.size() < n; i++) @(posedge mclk);
    for (int i = 0; i < n; i++) chk({30'h0, gq[i]}, 32'(pick(wfq)));
  endtask
  initial begin
    reset();
    rd_reg(`EQS_A_CTRL);
    chk(rd, 32'h13);
    rd_reg(`EQS_A_QMAP);
    chk(rd, 32'hFA50);
    rd_reg(8'h3C);
    chk(rd, 32'h0);
    for (int p = 0; p < 8; p++) begin
      frame(1'b0, 1'b0, 3'h0, 1'b1, {3'(p), 5'h0B}, 11'h040);
      chk({29'h0, q}, 32'(p / 2));
      frame(1'b0, 1'b1, 3'(p), 1'b1, {3'(7 - p), 5'h00}, 11'h040);
      chk({29'h0, q}, 32'(p / 2));
      m[3 * p +: 3] = 3'(7 - p);
    end
    wr(`EQS_A_CTRL, 32'h17);
    for (int p = 0; p < 8; p++) begin
      frame(1'b0, 1'b1, 3'(p), 1'b1, {3'(7 - p), 5'h00}, 11'h040);
      chk({29'h0, q}, 32'((7 - p) / 2));
    end
    wr(`EQS_A_CTRL, 32'h13);
    wr(`EQS_A_REMAP, {8'h00, m});
    for (int p = 0; p < 8; p++) begin
      frame(1'b0, 1'b1, 3'(p), 1'b0, 8'h00, 11'h040);
      chk({29'h0, q}, 32'((7 - p) / 2));
    end
    // Port stalled all along: eight frames went to every queue
    rd_reg(`EQS_A_STAT);
    chk(rd, 32'h08080808);
    // Unclassified frames fill queue 0; the one past full is dropped
    for (int i = 0; i < 9; i++) begin
      frame(1'b0, 1'b0, 3'h0, 1'b0, 8'h00, 11'h040);
      chk({29'h0, q}, (i == 8) ? 32'h4 : 32'h0);
    end
    reset();
    fill_drain(1'b0);
    reset();
    wr(`EQS_A_CTRL, 32'h1B);
    fill_drain(1'b1);
    wr(`EQS_A_RATE, 32'h7F7F);
    rd_reg(`EQS_A_RATE);
    chk(rd, 32'h5A5A);
    wr(`EQS_A_RATE, 32'h0001);
    wr(`EQS_A_DROP, 32'h0);
    frame(1'b1, 1'b1, 3'h7, 1'b0, 8'h00, 11'h12C);
    chk({31'h0, q[2]}, 32'h1);
    frame(1'b0, 1'b1, 3'h7, 1'b0, 8'h00, 11'h12C);
    chk({31'h0, q[2]}, 32'h0);
    frame(1'b1, 1'b1, 3'h7, 1'b0, 8'h00, 11'h040);
    chk({31'h0, q[2]}, 32'h0);
    rd_reg(`EQS_A_DROP);
    chk(rd, 32'h1);
    // Egress limit of 1 Mbps: the bucket covers only a few 64-byte frames
    wr(`EQS_A_RATE, 32'h0100);
    for (int i = 0; i < 12; i++) frame(1'b0, 1'b1, 3'h7, 1'b0, 8'h00, 11'h040);
    repeat (300) @(posedge mclk);
    rd_reg(`EQS_A_STAT);
    chk({31'h0, rd[31:24] != 8'h00}, 32'h1);
    // Limit lifted: the held frames drain
    wr(`EQS_A_RATE, 32'h0000);
    repeat (300) @(posedge mclk);
    rd_reg(`EQS_A_STAT);
    chk(rd, 32'h0);
    test_done();
  end
endmodule // eqs_sched_tb_top
bind eqs_sched eqs_sched_props u_props (.mclk(mclk), .rstn(rstn), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .in_valid(in_valid), .cls_valid(cls_valid), .cls_drop(cls_drop),
  .cls_queue(cls_queue), .eg_ready(eg_ready), .tx_grant(tx_grant), .tx_queue(tx_queue));
`default_nettype wire
